/* rtl/tcd_pkg.sv */
// package: register map, field layouts and timing constants of the terminal command decoder
package tcd_pkg;
  // byte addresses of the registers on the apb bus
  localparam logic [7:0] ADDR_FILTER_TIME = 8'h00;
  localparam logic [7:0] ADDR_CMD_MODE = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_MAX_FREQ = 8'h0c;
  localparam logic [7:0] ADDR_FUNC_CODES = 8'h10;
  localparam logic [7:0] ADDR_RAMP_BASE = 8'h20;
  localparam logic [7:0] ADDR_REF_BASE = 8'h40;
  // number of terminals and reference table size
  localparam int NUM_TERM = 10;
  localparam int NUM_REF = 16;
  localparam int NUM_RAMP = 4;
  // filter time register counts milliseconds; default 10 ms, range 0 to 1000 ms
  localparam logic [15:0] FILTER_RESET = 16'h000a;
  localparam logic [15:0] FILTER_MAX = 16'h03e8;
  localparam int CLK_HZ = 20000000;
  localparam int FILTER_UNIT_NS = 1000000;
  localparam int CLK_NS = 1000000000 / CLK_HZ;
  localparam logic [15:0] CYCLES_PER_MS = 16'(FILTER_UNIT_NS / CLK_NS);
  // terminal command modes
  localparam logic [1:0] MODE_TWO_LINE1 = 2'h0;
  localparam logic [1:0] MODE_TWO_LINE2 = 2'h1;
  localparam logic [1:0] MODE_THREE_LINE1 = 2'h2;
  localparam logic [1:0] MODE_THREE_LINE2 = 2'h3;
  localparam logic [1:0] MODE_RESET = 2'h0;
  // terminal function codes
  localparam logic [7:0] FUNC_FWD = 8'h01;
  localparam logic [7:0] FUNC_REV = 8'h02;
  localparam logic [7:0] FUNC_THREE_LINE = 8'h03;
  // reset terminal assignments: forward on terminal 4, reverse on 5, enable on 2
  localparam logic [3:0] FWD_TERM_RESET = 4'h4;
  localparam logic [3:0] REV_TERM_RESET = 4'h5;
  localparam logic [3:0] EN_TERM_RESET = 4'h2;
  // fixed terminal positions of select functions
  localparam int SEL_REF_LSB = 0;
  localparam int SEL_RAMP_LSB = 4;
  localparam int SEL_MOTOR_LSB = 6;
  // 100 % in reference registers is 16'h2710 (10000 = 100.00 %)
  localparam logic [15:0] REF_FULL_SCALE = 16'h2710;
  localparam logic [15:0] MAX_FREQ_RESET = 16'h1388;
  // run state enum
  typedef enum logic [1:0] {
    TCD_STOP = 2'b00,
    TCD_FWD = 2'b01,
    TCD_REV = 2'b10
  } tcd_run_e;
endpackage

/* rtl/tcd_filt_if.sv */
// interface: filter time and filtered terminal levels between decoder and filter
`timescale 1ns/100ps
interface tcd_filt_if;
  logic [15:0] filter_ms;
  logic [9:0] raw;
  logic [9:0] level;
  modport ctrl (output filter_ms, output raw, input level);
  modport filt (input filter_ms, input raw, output level);
endinterface

/* rtl/tcd_filter.sv */
// module: per-terminal stability filter, accepts a level after the programmed time
`timescale 1ns/100ps
module tcd_filter (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // filter link
  tcd_filt_if.filt fl
);
  typedef struct packed {
    logic [9:0] level;
    logic [15:0] tick;
    logic [9:0][15:0] ms;
  } tcd_filt_s;
  tcd_filt_s st, next_st;

  // one millisecond prescaler shared by all terminals; each terminal counts stable ms
  always_comb begin
    next_st = st;
    if (st.tick == tcd_pkg::CYCLES_PER_MS - 16'h0001) begin
      next_st.tick = '0;
    end else begin
      next_st.tick = st.tick + 16'h0001;
    end
    for (int i = 0; i < tcd_pkg::NUM_TERM; i++) begin
      if (fl.raw[i] == st.level[i]) begin
        next_st.ms[i] = '0;
      // the shared prescaler may tick at once, so one extra tick guarantees the full time
      end else if (st.ms[i] > fl.filter_ms || fl.filter_ms == 16'h0000) begin
        next_st.level[i] = fl.raw[i]; // R6 R17
        next_st.ms[i] = '0;
      end else if (st.tick == '0) begin
        next_st.ms[i] = st.ms[i] + 16'h0001; // R17
      end
    end
  end

  // state register
  always_ff @(posedge mclk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign fl.level = st.level;
endmodule

/* rtl/tcd_top.sv */
// module: terminal command decoder with apb registers
`timescale 1ns/100ps
// Contract
// R1 - four select inputs form reference index, first input is lsb
// R2 - reference of full scale equals maximum output frequency
// R3 - selected reference also offered as pid setpoint and vf voltage source
// R4 - two ramp inputs pick one of four accel/decel time sets
// R5 - two motor inputs pick one of four motor parameter groups
// R6 - every terminal filtered, time 0 to 1 s, default 10 ms
// R7 - command mode register, four encodings, reset 0
// R8 - mode 0: forward only fwd, reverse only rev, else stop
// R9 - mode 1: enable plus direction input
// R10 - mode 2: with enable, fwd or rev button starts that direction
// R11 - three-line modes stop at once when enable drops
// R12 - controller keeps enable active during startup and run
// R13 - mode 2: last valid command decides run state
// R14 - mode 3: enable, run button, direction input
// R15 - command inputs found by function codes 1, 2, 3
// R16 - mode 3: run button starts, direction input picks way
// R17 - new level accepted only after stable for filter time
module tcd_top (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // terminals
  input wire logic [9:0] terminal_in,
  // decoded outputs
  output logic [3:0] ref_index,
  output logic [31:0] speed_reference,
  output logic [15:0] pid_setpoint,
  output logic [15:0] vf_voltage_ref,
  output logic [1:0] ramp_set,
  output logic [15:0] accel_time,
  output logic [15:0] decel_time,
  output logic [1:0] motor_group,
  output logic run_cmd,
  output logic forward_run_function,
  output logic reverse_run_function,
  output logic stop_cmd
);
  typedef struct packed {
    logic [15:0] filter_ms;
    logic [1:0] mode;
    logic [15:0] max_freq;
    logic [3:0] fwd_term;
    logic [3:0] rev_term;
    logic [3:0] en_term;
    logic [15:0][15:0] refs;
    logic [7:0][15:0] ramps;
    logic [2:0] prev_cmd;
    tcd_pkg::tcd_run_e run;
    logic [31:0] rdata;
    logic [3:0] ref_index;
    logic [31:0] speed;
    logic [1:0] ramp_set;
    logic [15:0] accel;
    logic [15:0] decel;
    logic [1:0] motor;
  } tcd_s;
  tcd_s st, next_st;

  tcd_filt_if fl ();
  logic [9:0] lvl;
  logic fwd_in, rev_in, en_in;
  logic fwd_rise, rev_rise;
  logic wr_en, rd_en;

  // filter block handles the debounce of all terminals
  tcd_filter u_filter (
    .mclk(mclk),
    .srst(srst),
    .fl(fl)
  );
  assign fl.filter_ms = st.filter_ms;
  assign fl.raw = terminal_in;
  assign lvl = fl.level;

  // pick a terminal by its programmed number; an out-of-range number reads as off
  function automatic logic pick(input logic [9:0] v, input logic [3:0] n);
    pick = (n < 4'(tcd_pkg::NUM_TERM)) ? v[n] : 1'b0;
  endfunction

  // table address decode, shared by the write and the read path
  function automatic logic is_ref(input logic [7:0] a);
    is_ref = (a >= tcd_pkg::ADDR_REF_BASE) && (a < 8'h80) && (a[1:0] == 2'h0);
  endfunction
  function automatic logic is_ramp(input logic [7:0] a);
    is_ramp = (a >= tcd_pkg::ADDR_RAMP_BASE) && (a < tcd_pkg::ADDR_REF_BASE) && (a[1:0] == 2'h0);
  endfunction

  // command inputs located through their function assignment
  assign fwd_in = pick(lvl, st.fwd_term); // R15
  assign rev_in = pick(lvl, st.rev_term); // R15
  assign en_in = pick(lvl, st.en_term); // R15
  assign fwd_rise = fwd_in & ~st.prev_cmd[0];
  assign rev_rise = rev_in & ~st.prev_cmd[1];

  // apb: zero wait states, writes act in the access phase, reads capture in the setup phase
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & ~penable & ~pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;

  always_comb begin
    next_st = st;
    next_st.prev_cmd = {en_in, rev_in, fwd_in};
    // register writes; filter time clamps at one second
    if (wr_en) begin
      case (paddr)
        tcd_pkg::ADDR_FILTER_TIME: begin
          next_st.filter_ms = (pwdata[15:0] > tcd_pkg::FILTER_MAX) ?
                              tcd_pkg::FILTER_MAX : pwdata[15:0]; // R6
        end
        tcd_pkg::ADDR_CMD_MODE: begin
          next_st.mode = pwdata[1:0]; // R7
        end
        tcd_pkg::ADDR_MAX_FREQ: begin
          next_st.max_freq = pwdata[15:0];
        end
        tcd_pkg::ADDR_FUNC_CODES: begin
          next_st.fwd_term = pwdata[3:0];
          next_st.rev_term = pwdata[11:8];
          next_st.en_term = pwdata[19:16];
        end
        default: begin
          if (is_ref(paddr)) begin
            next_st.refs[paddr[5:2]] = pwdata[15:0];
          end else if (is_ramp(paddr)) begin
            next_st.ramps[paddr[4:2]] = pwdata[15:0];
          end
        end
      endcase
    end
    // read data captured in setup, held through the access phase
    if (rd_en) begin
      case (paddr)
        tcd_pkg::ADDR_FILTER_TIME: next_st.rdata = {16'h0000, st.filter_ms};
        tcd_pkg::ADDR_CMD_MODE: next_st.rdata = {30'h00000000, st.mode};
        tcd_pkg::ADDR_STATUS: begin
          next_st.rdata = {8'h00, 2'h0, lvl, st.motor, st.ramp_set, st.ref_index, 2'h0, st.run};
        end
        tcd_pkg::ADDR_MAX_FREQ: next_st.rdata = {16'h0000, st.max_freq};
        tcd_pkg::ADDR_FUNC_CODES: begin
          next_st.rdata = {12'h000, st.en_term, 4'h0, st.rev_term, 4'h0, st.fwd_term};
        end
        default: begin
          if (is_ref(paddr)) begin
            next_st.rdata = {16'h0000, st.refs[paddr[5:2]]};
          end else if (is_ramp(paddr)) begin
            next_st.rdata = {16'h0000, st.ramps[paddr[4:2]]};
          end else begin
            next_st.rdata = '0;
          end
        end
      endcase
    end
    // selectors work on filtered levels only
    next_st.ref_index = lvl[tcd_pkg::SEL_REF_LSB +: 4]; // R1
    next_st.speed = 32'((32'(st.refs[st.ref_index]) * 32'(st.max_freq))
                        / 32'(tcd_pkg::REF_FULL_SCALE)); // R2
    next_st.ramp_set = lvl[tcd_pkg::SEL_RAMP_LSB +: 2]; // R4
    next_st.accel = st.ramps[{st.ramp_set, 1'b0}]; // R4
    next_st.decel = st.ramps[{st.ramp_set, 1'b1}]; // R4
    next_st.motor = lvl[tcd_pkg::SEL_MOTOR_LSB +: 2]; // R5
    // run command per terminal mode
    case (st.mode)
      tcd_pkg::MODE_TWO_LINE1: begin
        if (fwd_in && !rev_in) begin
          next_st.run = tcd_pkg::TCD_FWD; // R8
        end else if (rev_in && !fwd_in) begin
          next_st.run = tcd_pkg::TCD_REV; // R8
        end else begin
          next_st.run = tcd_pkg::TCD_STOP; // R8
        end
      end
      tcd_pkg::MODE_TWO_LINE2: begin
        if (!fwd_in) begin
          next_st.run = tcd_pkg::TCD_STOP; // R9
        end else begin
          next_st.run = rev_in ? tcd_pkg::TCD_REV : tcd_pkg::TCD_FWD; // R9
        end
      end
      tcd_pkg::MODE_THREE_LINE1: begin
        // latched run: the latest button press wins, enable loss overrides all
        if (!en_in) begin
          next_st.run = tcd_pkg::TCD_STOP; // R11
        end else if (fwd_rise && !rev_rise) begin
          next_st.run = tcd_pkg::TCD_FWD; // R10 R13
        end else if (rev_rise && !fwd_rise) begin
          next_st.run = tcd_pkg::TCD_REV; // R10 R13
        end
      end
      tcd_pkg::MODE_THREE_LINE2: begin
        if (!en_in) begin
          next_st.run = tcd_pkg::TCD_STOP; // R11
        end else if (fwd_rise || st.run != tcd_pkg::TCD_STOP) begin
          next_st.run = rev_in ? tcd_pkg::TCD_REV : tcd_pkg::TCD_FWD; // R14 R16
        end
      end
      default: next_st.run = tcd_pkg::TCD_STOP;
    endcase
  end

  // state register with documented reset values
  always_ff @(posedge mclk) begin
    if (srst) begin
      st <= '0;
      st.filter_ms <= tcd_pkg::FILTER_RESET; // R6
      st.mode <= tcd_pkg::MODE_RESET; // R7
      st.max_freq <= tcd_pkg::MAX_FREQ_RESET;
      st.fwd_term <= tcd_pkg::FWD_TERM_RESET;
      st.rev_term <= tcd_pkg::REV_TERM_RESET;
      st.en_term <= tcd_pkg::EN_TERM_RESET;
      st.run <= tcd_pkg::TCD_STOP;
    end else begin
      st <= next_st;
    end
  end

  // outputs straight from the state flops
  assign prdata = st.rdata;
  assign ref_index = st.ref_index;
  assign speed_reference = st.speed;
  assign pid_setpoint = st.refs[st.ref_index]; // R3
  assign vf_voltage_ref = st.refs[st.ref_index]; // R3
  assign ramp_set = st.ramp_set;
  assign accel_time = st.accel;
  assign decel_time = st.decel;
  assign motor_group = st.motor;
  assign forward_run_function = (st.run == tcd_pkg::TCD_FWD);
  assign reverse_run_function = (st.run == tcd_pkg::TCD_REV);
  assign run_cmd = (st.run != tcd_pkg::TCD_STOP);
  assign stop_cmd = (st.run == tcd_pkg::TCD_STOP);
endmodule

/* sim/tcd_switch_model.sv */
// switch model: external switches and buttons feeding the terminals
`timescale 1ns/100ps
module tcd_switch_model (
  // clock
  input wire logic mclk,
  // contact positions asked for by the bench
  input wire logic [9:0] want,
  // terminal levels
  output logic [9:0] terminal_in
);
  initial terminal_in = 10'h000;
  // contacts move on the drive clock; the enable contact is only opened on purpose
  always @(posedge mclk) begin
    terminal_in <= want;
  end
endmodule

/* sim/tcd_top_checker.sv */
// checker: port assertions for the terminal command decoder
`timescale 1ns/100ps
module tcd_top_checker (
  // clock and reset
  input wire logic mclk,
  input wire logic srst,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // terminals and decoded outputs
  input wire logic [9:0] terminal_in,
  input wire logic [1:0] motor_group,
  input wire logic [15:0] pid_setpoint,
  input wire logic [15:0] vf_voltage_ref,
  input wire logic run_cmd,
  input wire logic forward_run_function,
  input wire logic reverse_run_function,
  input wire logic stop_cmd
);
  default clocking dcb @(posedge mclk); endclocking
  default disable iff (srst);
  logic [1:0] mode_q;
  logic [15:0] filt_q;
  logic [3:0] en_q;
  logic en_pin;
  // shadow of the three settings (mode, enable terminal, filter time) as software last wrote them
  always_ff @(posedge mclk) begin
    if (srst) begin
      mode_q <= tcd_pkg::MODE_RESET;
      filt_q <= tcd_pkg::FILTER_RESET;
      en_q <= tcd_pkg::EN_TERM_RESET;
    end else if (psel && penable && pwrite && paddr == tcd_pkg::ADDR_CMD_MODE) begin
      mode_q <= pwdata[1:0];
    end else if (psel && penable && pwrite && paddr == tcd_pkg::ADDR_FUNC_CODES) begin
      en_q <= pwdata[19:16];
    end else if (psel && penable && pwrite && paddr == tcd_pkg::ADDR_FILTER_TIME) begin
      // values past one second clamp rather than wrap
      filt_q <= (pwdata[15:0] > tcd_pkg::FILTER_MAX) ? tcd_pkg::FILTER_MAX : pwdata[15:0];
    end
  end
  // enable pin as the design locates it; an unmapped number reads as off
  assign en_pin = (en_q < 4'ha) ? terminal_in[en_q] : 1'b0;
  // three cycles of a low enable pin in a three-line mode with no filter delay
  sequence en_low3;
    (mode_q[1] && filt_q == 16'h0000 && !en_pin) [*3];
  endsequence
  sequence rd_mode;
    psel && penable && !pwrite && paddr == tcd_pkg::ADDR_CMD_MODE;
  endsequence
  sequence rd_filt;
    psel && penable && !pwrite && paddr == tcd_pkg::ADDR_FILTER_TIME;
  endsequence
  apb_ready_a: assert property (psel |-> pready)
    else $error("apb access not ready");
  no_slverr_a: assert property (psel && penable |-> !pslverr)
    else $error("slave error raised");
  mode_echo_a: assert property (rd_mode |-> prdata == {30'h0, mode_q})
    else $error("mode read back wrong");
  filt_echo_a: assert property (rd_filt |-> prdata == {16'h0, filt_q})
    else $error("filter time read back wrong");
  run_excl_a: assert property ($onehot({forward_run_function, reverse_run_function, stop_cmd}))
    else $error("run outputs not exclusive");
  run_stop_a: assert property (run_cmd != stop_cmd)
    else $error("run and stop disagree");
  enable_stop_a: assert property (en_low3 |-> stop_cmd)
    else $error("three-line mode kept running without enable");
  pid_vf_a: assert property (pid_setpoint == vf_voltage_ref)
    else $error("setpoint and voltage source differ");
  reset_stop_a: assert property ($fell(srst) |-> stop_cmd && motor_group == 2'h0)
    else $error("not stopped after reset");
  motor_sel_a: assert property ($changed(motor_group) |->
    motor_group == $past(terminal_in[7:6]) || motor_group == $past(terminal_in[7:6], 2)
    || motor_group == $past(terminal_in[7:6], 3) || motor_group == $past(terminal_in[7:6], 4))
    else $error("motor group not from pins");
endmodule
bind tcd_top tcd_top_checker u_chk (
  .mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .terminal_in, .motor_group, .pid_setpoint, .vf_voltage_ref, .run_cmd,
  .forward_run_function, .reverse_run_function, .stop_cmd
);

/* sim/tb_terminal_command_decoder.sv */
// testbench: apb and terminal scenarios for the terminal command decoder
`timescale 1ns/100ps
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_terminal_command_decoder;
  logic mclk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd, speed_reference;
  logic pready, pslverr, run_cmd, forward_run_function, reverse_run_function, stop_cmd;
  logic [9:0] want = 10'h000, terminal_in;
  logic [3:0] ref_index;
  logic [15:0] pid_setpoint, vf_voltage_ref, accel_time, decel_time;
  logic [1:0] ramp_set, motor_group;
  int fail_count = 0, samples_checked = 0, i;
  // two-line table: enable/forward on bit 8, reverse/direction on bit 9
  logic [9:0] tv [8] = '{10'h000, 10'h100, 10'h200, 10'h300, 10'h000, 10'h100, 10'h300, 10'h200};
  logic [1:0] te [8] = '{2'h0, 2'h1, 2'h2, 2'h0, 2'h0, 2'h1, 2'h2, 2'h0};
  tcd_top DUT (
    .mclk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .terminal_in, .ref_index, .speed_reference, .pid_setpoint, .vf_voltage_ref, .ramp_set,
    .accel_time, .decel_time, .motor_group, .run_cmd, .forward_run_function,
    .reverse_run_function, .stop_cmd
  );
  tcd_switch_model u_sw (
    .mclk, .want, .terminal_in
  );
  initial forever #25 mclk = ~mclk;
  task end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  // one apb transfer; read data taken at the edge that sees pready
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge mclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 16) begin
      fail_count++;
      $display("Error at %0t: no pready", $time);
      end_sim();
    end
  endtask
  task chk_rd(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    `CHK(rd, e);
  endtask
  // settle time covers model stage, zero filter and output register
  task drive(input logic [9:0] v);
    want <= v;
    repeat (8) @(posedge mclk);
  endtask
  task run_is(input logic [1:0] c);
    `CHK({forward_run_function, reverse_run_function, stop_cmd}, {c == 2'h1, c == 2'h2, c == 2'h0});
    `CHK(run_cmd, c != 2'h0);
  endtask
  initial begin
    repeat (5) @(posedge mclk);
    srst <= 1'b0;
    chk_rd(tcd_pkg::ADDR_FILTER_TIME, {16'h0, tcd_pkg::FILTER_RESET});
    chk_rd(tcd_pkg::ADDR_CMD_MODE, 32'h0);
    chk_rd(tcd_pkg::ADDR_MAX_FREQ, {16'h0, tcd_pkg::MAX_FREQ_RESET});
    chk_rd(tcd_pkg::ADDR_FUNC_CODES, 32'h00020504);
    chk_rd(8'hfc, 32'h0);
    xfer(1'b1, tcd_pkg::ADDR_FILTER_TIME, 32'h1388);
    chk_rd(tcd_pkg::ADDR_FILTER_TIME, 32'h03e8);
    xfer(1'b1, tcd_pkg::ADDR_FILTER_TIME, 32'h0);
    $display("test registers done");
    for (i = 0; i < 16; i++) xfer(1'b1, tcd_pkg::ADDR_REF_BASE + 8'(4 * i), 32'h0100 + i);
    for (i = 0; i < 16; i++) begin
      drive(10'(i));
      `CHK(ref_index, 4'(i));
      `CHK(pid_setpoint, 16'(16'h0100 + i));
    end
    xfer(1'b1, tcd_pkg::ADDR_MAX_FREQ, 32'h0fa0);
    xfer(1'b1, tcd_pkg::ADDR_REF_BASE + 8'h3c, {16'h0, tcd_pkg::REF_FULL_SCALE});
    xfer(1'b1, tcd_pkg::ADDR_REF_BASE + 8'h38, 32'h1388);
    drive(10'h00f);
    `CHK(speed_reference, 32'h0fa0);
    drive(10'h00e);
    `CHK(speed_reference, 32'h07d0);
    $display("test references done");
    for (i = 0; i < 8; i++) xfer(1'b1, tcd_pkg::ADDR_RAMP_BASE + 8'(4 * i), 32'h0a00 + i);
    for (i = 0; i < 4; i++) begin
      drive(10'(i << 4 | i << 6));
      `CHK(ramp_set, 2'(i));
      `CHK(accel_time, 16'(16'h0a00 + 2 * i));
      `CHK(decel_time, 16'(16'h0a01 + 2 * i));
      `CHK(motor_group, 2'(i));
    end
    $display("test selects done");
    xfer(1'b1, tcd_pkg::ADDR_FUNC_CODES, 32'h00020908);
    for (i = 0; i < 8; i++) begin
      if (i % 4 == 0) xfer(1'b1, tcd_pkg::ADDR_CMD_MODE, 32'(i / 4));
      drive(tv[i]);
      run_is(te[i]);
    end
    // three-line mode 1: enable on bit 2, buttons pulsed
    xfer(1'b1, tcd_pkg::ADDR_CMD_MODE, 32'h2);
    drive(10'h104);
    drive(10'h004);
    run_is(2'h1);
    drive(10'h204);
    drive(10'h004);
    run_is(2'h2);
    drive(10'h104);
    drive(10'h100);
    run_is(2'h0);
    // three-line mode 2: run button on bit 8, direction on bit 9
    xfer(1'b1, tcd_pkg::ADDR_CMD_MODE, 32'h3);
    drive(10'h204);
    run_is(2'h0);
    drive(10'h304);
    drive(10'h204);
    run_is(2'h2);
    drive(10'h004);
    run_is(2'h1);
    drive(10'h200);
    run_is(2'h0);
    $display("test commands done");
    // one millisecond filter: a short pulse is dropped, a steady level lands late
    drive(10'h000);
    xfer(1'b1, tcd_pkg::ADDR_CMD_MODE, 32'h0);
    xfer(1'b1, tcd_pkg::ADDR_FILTER_TIME, 32'h1);
    drive(10'h100);
    drive(10'h000);
    repeat (100) @(posedge mclk);
    run_is(2'h0);
    want <= 10'h100;
    repeat (15000) @(posedge mclk);
    run_is(2'h0);
    for (i = 0; i < 30000 && forward_run_function !== 1'b1; i++) @(posedge mclk);
    if (i == 30000) begin
      fail_count++;
      $display("Error at %0t: filtered level never landed", $time);
      end_sim();
    end
    run_is(2'h1);
    chk_rd(tcd_pkg::ADDR_STATUS, 32'h00100001);
    $display("test filter done");
    end_sim();
  end
endmodule
